/* File: src/adc_ctrl_defines.svh */
// Register offsets, field positions, reset values and timing counts for the converter control
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_MISC 3'h0
`define OFS_MUX 3'h1
`define OFS_CSA 3'h2
`define OFS_CSB 3'h3
`define OFS_RES_LO 3'h4
`define OFS_RES_HI 3'h5

// ****************************************
// Field positions
// ****************************************
`define MISC_SRC_BIT 0
`define MISC_XREF_BIT 1
`define MISC_REFOUT_BIT 2
`define MISC_MASK 8'h07
`define MUX_CH_LSB 0
`define MUX_LAR_BIT 5
`define MUX_REF_LSB 6
`define CSA_PS_LSB 0
`define CSA_IF_BIT 4
`define CSA_ATE_BIT 5
`define CSA_SC_BIT 6
`define CSA_EN_BIT 7
`define CSB_TS_LSB 0
`define CSB_MASK 8'h07

// ****************************************
// Reset values and timing
// ****************************************
`define RESET_BYTE 8'h00
`define CONV_NORMAL 5'd13
`define CONV_FIRST 5'd25
`define TRIG_FREE 3'h0

`endif

/* File: src/adc_ctrl_pkg.sv */
// Types shared by the converter control logic
package adc_ctrl_pkg;
    typedef enum logic [1:0] {IDLE, WAIT_EDGE, CONVERT} conv_state_e;
    typedef logic [7:0] byte_t;
endpackage : adc_ctrl_pkg

/* File: src/sar_adc_control.sv */
// Converter control: registers, start and trigger logic, result lock
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module sar_adc_control #(
    parameter int TRIG_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire adc_ctrl_pkg::byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    output adc_ctrl_pkg::byte_t rdata,
    input wire logic [TRIG_W-1:0] trigger_sources,
    input wire logic [9:0] sar_result,
    output logic internal_current_source,
    output logic reference_output_enable,
    output logic external_reference_enable,
    output logic [1:0] reference_select,
    output logic [4:0] channel_select,
    output logic analog_enable,
    output logic sar_sample,
    output logic conversion_done
);
    import adc_ctrl_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    byte_t misc_r;
    logic [4:0] ch_tmp_r;
    logic lar_r;
    logic [1:0] ref_tmp_r;
    logic en_r;
    logic sc_r;
    logic ate_r;
    logic if_r;
    logic [2:0] ps_r;
    logic [2:0] ts_r;
    logic [9:0] result_r;
    logic lock_r;
    logic first_r;
    conv_state_e state_r;
    logic [6:0] pre_r;
    logic [4:0] cyc_r;
    logic [TRIG_W-1:0] trig_s1_r;
    logic [TRIG_W-1:0] trig_s2_r;
    logic trig_prev_r;
    logic [4:0] ch_act_r;
    logic [1:0] ref_act_r;

    logic wr_misc;
    logic wr_mux;
    logic wr_csa;
    logic wr_csb;
    logic rd_lo;
    logic rd_hi;
    logic trig_level;
    logic trig_edge;
    logic adc_tick;
    logic done;
    logic start_req;
    logic busy;
    logic free_run;

    // Divider ratio from prescaler select, 2 to 128
    function automatic logic [6:0] ps_mask(input logic [2:0] ps);
        logic [6:0] m;
        m = 7'h01;
        if (ps != 3'h0)
        begin
            m = 7'(({7'h0, 1'b1} << ps) - 8'h01);
        end
        return m;
    endfunction : ps_mask

    // Place the ten-bit result in one byte lane
    function automatic byte_t result_byte(input logic [9:0] r, input logic lar,
                                          input logic hi);
        logic [15:0] w;
        w = lar ? {r, 6'h00} : {6'h00, r};
        return hi ? w[15:8] : w[7:0];
    endfunction : result_byte

    // ****************************************
    // Bus decode
    // ****************************************
    assign wr_misc = wr && (addr == `OFS_MISC);
    assign wr_mux = wr && (addr == `OFS_MUX);
    assign wr_csa = wr && (addr == `OFS_CSA);
    assign wr_csb = wr && (addr == `OFS_CSB);
    assign rd_lo = rd && (addr == `OFS_RES_LO);
    assign rd_hi = rd && (addr == `OFS_RES_HI);
    assign busy = (state_r != IDLE);

    always_ff @(posedge clk)
    begin
        if (!resetn)
            misc_r <= `RESET_BYTE;
        else if (ce && wr_misc)
            misc_r <= wdata & `MISC_MASK;
    end

    // Temporary channel, reference and justify settings
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ch_tmp_r <= 5'h00;
            lar_r <= 1'b0;
            ref_tmp_r <= 2'h0;
        end
        else if (ce && wr_mux)
        begin
            ch_tmp_r <= wdata[`MUX_CH_LSB +: 5];
            lar_r <= wdata[`MUX_LAR_BIT];
            ref_tmp_r <= wdata[`MUX_REF_LSB +: 2];
        end
    end

    // Control register A fields other than start and flag
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            en_r <= 1'b0;
            ate_r <= 1'b0;
            ps_r <= 3'h0;
        end
        else if (ce && wr_csa)
        begin
            en_r <= wdata[`CSA_EN_BIT];
            ate_r <= wdata[`CSA_ATE_BIT];
            ps_r <= wdata[`CSA_PS_LSB +: 3];
        end
    end

    // Trigger source select
    always_ff @(posedge clk)
    begin
        if (!resetn)
            ts_r <= 3'h0;
        else if (ce && wr_csb)
            ts_r <= wdata[`CSB_TS_LSB +: 3];
    end

    // ****************************************
    // Trigger path
    // ****************************************
    // External trigger flags pass two flip-flops
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            trig_s1_r <= '0;
            trig_s2_r <= '0;
        end
        else if (ce)
        begin
            trig_s1_r <= trigger_sources;
            trig_s2_r <= trig_s1_r;
        end
    end

    // Own complete flag as source: free run, first start by software
    assign free_run = ate_r && (ts_r == `TRIG_FREE);
    assign trig_level = trig_s2_r[ts_r];
    // Flag must fall before next edge counts
    assign trig_edge = ate_r && en_r && !free_run && trig_level && !trig_prev_r;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            trig_prev_r <= 1'b0;
        else if (ce)
            trig_prev_r <= trig_level;
    end

    // ****************************************
    // Prescaler and conversion sequencer
    // ****************************************
    // Prescaler cleared while disabled
    always_ff @(posedge clk)
    begin
        if (!resetn)
            pre_r <= 7'h00;
        else if (ce)
        begin
            if (!en_r || (trig_edge && !busy))
                pre_r <= 7'h00;
            else
                pre_r <= 7'(pre_r + 7'h01);
        end
    end

    assign adc_tick = en_r && ((pre_r & ps_mask(ps_r)) == ps_mask(ps_r));
    assign done = (state_r == CONVERT) && adc_tick &&
                  (cyc_r == (first_r ? `CONV_FIRST : `CONV_NORMAL) - 5'd1);
    // Software start works in any mode
    assign start_req = ce && wr_csa && wdata[`CSA_SC_BIT] && wdata[`CSA_EN_BIT];

    // Software start waits for next converter edge; trigger edge starts at once
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_r <= IDLE;
            cyc_r <= 5'h00;
        end
        else if (ce)
        begin
            if (!en_r && !start_req)
            begin
                state_r <= IDLE;
                cyc_r <= 5'h00;
            end
            else
            begin
                unique case (state_r)
                    IDLE:
                    begin
                        if (trig_edge)
                            state_r <= CONVERT;
                        else if (start_req)
                            state_r <= WAIT_EDGE;
                    end
                    WAIT_EDGE:
                    begin
                        if (adc_tick)
                            state_r <= CONVERT;
                    end
                    CONVERT:
                    begin
                        if (done)
                        begin
                            cyc_r <= 5'h00;
                            if (!free_run)
                                state_r <= IDLE;
                        end
                        else if (adc_tick)
                            cyc_r <= 5'(cyc_r + 5'd1);
                    end
                endcase
            end
        end
    end

    // First conversion after enable is long
    always_ff @(posedge clk)
    begin
        if (!resetn)
            first_r <= 1'b1;
        else if (ce)
        begin
            if (!en_r)
                first_r <= 1'b1;
            else if (done)
                first_r <= 1'b0;
        end
    end

    // Start bit stays high until a completion outside free run, or until disabled
    always_ff @(posedge clk)
    begin
        if (!resetn)
            sc_r <= 1'b0;
        else if (ce)
        begin
            if (done && !free_run)
                sc_r <= 1'b0;
            else if (start_req || trig_edge)
                sc_r <= 1'b1;
            else if (!en_r)
                sc_r <= 1'b0;
        end
    end

    // Flag set at every completion; set wins over clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
            if_r <= 1'b0;
        else if (ce)
        begin
            if (done)
                if_r <= 1'b1;
            else if (wr_csa && wdata[`CSA_IF_BIT])
                if_r <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ch_act_r <= 5'h00;
            ref_act_r <= 2'h0;
        end
        else if (ce && en_r && (state_r != CONVERT || done))
        begin
            ch_act_r <= ch_tmp_r;
            ref_act_r <= ref_tmp_r;
        end
    end

    // ****************************************
    // Result registers and lock
    // ****************************************
    // Low byte read blocks updates
    always_ff @(posedge clk)
    begin
        if (!resetn)
            lock_r <= 1'b0;
        else if (ce)
        begin
            if (rd_hi)
                lock_r <= 1'b0;
            else if (rd_lo)
                lock_r <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            result_r <= 10'h000;
        else if (ce && done && !lock_r && !rd_lo)
            result_r <= sar_result;
    end

    // Justified read data one cycle later
    always_ff @(posedge clk)
    begin
        if (!resetn)
            rdata <= `RESET_BYTE;
        else if (ce)
        begin
            rdata <= `RESET_BYTE;
            if (rd)
            begin
                case (addr)
                    `OFS_MISC: rdata <= misc_r;
                    `OFS_MUX: rdata <= {ref_tmp_r, lar_r, ch_tmp_r};
                    `OFS_CSA: rdata <= {en_r, sc_r, ate_r, if_r, 1'b0, ps_r};
                    `OFS_CSB: rdata <= {5'h00, ts_r};
                    `OFS_RES_LO: rdata <= result_byte(result_r, lar_r, 1'b0);
                    `OFS_RES_HI: rdata <= result_byte(result_r, lar_r, 1'b1);
                    default: rdata <= `RESET_BYTE;
                endcase
            end
        end
    end

    // ****************************************
    // Analog side controls
    // ****************************************
    // Completion pulse one cycle after done; start bit cleared with it only outside free run
    always_ff @(posedge clk)
    begin
        if (!resetn)
            conversion_done <= 1'b0;
        else if (ce)
            conversion_done <= done;
        else
            conversion_done <= 1'b0;
    end

    // Sample pulse at conversion start
    always_ff @(posedge clk)
    begin
        if (!resetn)
            sar_sample <= 1'b0;
        else if (ce)
            sar_sample <= en_r && ((done && free_run) || ((state_r != CONVERT) &&
                          (trig_edge || (state_r == WAIT_EDGE && adc_tick))));
        else
            sar_sample <= 1'b0;
    end

    // Codes passed to the analog mux and gain stage
    assign channel_select = ch_act_r;
    assign reference_select = ref_act_r;
    assign analog_enable = en_r;
    // Current source follows its enable bit
    assign internal_current_source = misc_r[`MISC_SRC_BIT];
    assign reference_output_enable = misc_r[`MISC_REFOUT_BIT];
    assign external_reference_enable = misc_r[`MISC_XREF_BIT];

endmodule : sar_adc_control

/* File: sim/sar_adc_control_chk.sv */
// Port assertions for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module sar_adc_control_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire adc_ctrl_pkg::byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire adc_ctrl_pkg::byte_t rdata,
    input wire logic internal_current_source,
    input wire logic reference_output_enable,
    input wire logic external_reference_enable,
    input wire logic [1:0] reference_select,
    input wire logic [4:0] channel_select,
    input wire logic analog_enable,
    input wire logic sar_sample,
    input wire logic conversion_done
);
    import adc_ctrl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ****
    // Sequences
    // ****
    sequence misc_write;
        wr && ce && addr == `OFS_MISC;
    endsequence
    sequence quiet_run;
        (!conversion_done && !sar_sample) [*8];
    endsequence

    // ****
    // Assertions
    // ****
    a_source_follow: assert property (
        misc_write |=> internal_current_source == $past(wdata[0]))
        else $error("current source enable mismatch");
    a_ref_pins_follow: assert property (
        misc_write |=> {reference_output_enable, external_reference_enable} == $past(wdata[2:1]))
        else $error("reference pin enables mismatch");
    a_enable_follow: assert property (
        wr && ce && addr == `OFS_CSA |=> analog_enable == $past(wdata[7]))
        else $error("converter enable mismatch");
    a_sample_enabled: assert property (
        sar_sample |-> analog_enable)
        else $error("conversion started while disabled");
    a_run_quiet: assert property (
        sar_sample |=> quiet_run)
        else $error("conversion ended or restarted too early");
    a_done_single: assert property (
        conversion_done |=> !conversion_done)
        else $error("completion pulse longer than one cycle");
    a_sel_locked: assert property (
        sar_sample |=> ($stable(channel_select) && $stable(reference_select)) [*8])
        else $error("selection moved during conversion");
    a_misc_readback: assert property (
        rd && ce && addr == `OFS_MISC |=> rdata == {5'h00, $past(reference_output_enable),
        $past(external_reference_enable), $past(internal_current_source)})
        else $error("misc register read mismatch");
endmodule : sar_adc_control_chk

bind sar_adc_control sar_adc_control_chk chk_u (
    .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .internal_current_source(internal_current_source),
    .reference_output_enable(reference_output_enable),
    .external_reference_enable(external_reference_enable),
    .reference_select(reference_select), .channel_select(channel_select),
    .analog_enable(analog_enable), .sar_sample(sar_sample),
    .conversion_done(conversion_done)
);

/* File: sim/sar_core_model.sv */
// Behavioural model of the multiplexer, gain stage and approximation core
`timescale 1ns/1ps

module sar_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic analog_enable,
    input wire logic sar_sample,
    input wire logic [4:0] channel_select,
    output logic [9:0] sar_result
);
    logic [4:0] count_r;

    // ****
    // Sampling
    // ****
    // Each start captures the locked channel and a sample count; disabled core scrambles
    // ten-bit result
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            count_r <= 5'h00;
            sar_result <= 10'h000;
        end
        else if (sar_sample && analog_enable)
        begin
            count_r <= count_r + 5'h01;
            sar_result <= {channel_select, count_r + 5'h01};
        end
        else if (!analog_enable)
            sar_result <= ~sar_result;
    end
endmodule : sar_core_model

/* File: sim/sar_adc_control_and_trigger_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module sar_adc_control_and_trigger_tb;
    import adc_ctrl_pkg::*;
    logic clk;
    logic resetn;
    logic [2:0] addr;
    byte_t wdata;
    logic wr;
    logic rd;
    byte_t rdata;
    logic [7:0] trigger_sources;
    logic [9:0] sar_result;
    logic src_on;
    logic ref_out;
    logic ext_ref;
    logic [1:0] reference_select;
    logic [4:0] channel_select;
    logic analog_enable;
    logic sar_sample;
    logic conversion_done;
    int n_fail;
    int num_checks;
    int cycles;
    int len;

    sar_adc_control dut_u (
        .clk(clk), .resetn(resetn), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .trigger_sources(trigger_sources), .sar_result(sar_result),
        .internal_current_source(src_on), .reference_output_enable(ref_out),
        .external_reference_enable(ext_ref), .reference_select(reference_select),
        .channel_select(channel_select), .analog_enable(analog_enable),
        .sar_sample(sar_sample), .conversion_done(conversion_done)
    );
    sar_core_model core_u (
        .clk(clk), .resetn(resetn), .analog_enable(analog_enable), .sar_sample(sar_sample),
        .channel_select(channel_select), .sar_result(sar_result)
    );

    // ****
    // Clock, timeout and tasks
    // ****
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cuts a hung run short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [2:0] a, input byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_chk(input logic [2:0] a, input byte_t e, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, {2'b00, e}, {2'b00, rdata});
    endtask : rd_chk

    // Waits for the completion pulse under a bound; caller judges the outcome
    task automatic wait_done(output int c);
        c = 0;
        do
        begin
            @(posedge clk);
            #1;
            c++;
        end
        while (conversion_done !== 1'b1 && c < 300);
    endtask : wait_done

    // ****
    // Test sequence
    // ****
    initial
    begin
        resetn = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        trigger_sources = 8'h00;
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_chk(i[2:0], 8'h00, "reset or unmapped");
        wr_reg(`OFS_MISC, 8'hff);
        rd_chk(`OFS_MISC, 8'h07, "misc readback");
        chk("misc pins", 10'h007, {7'h00, ref_out, ext_ref, src_on});
        wr_reg(`OFS_MISC, 8'h00);
        chk("source off", 10'h000, {9'h000, src_on});
        // First single conversion on channel 3
        wr_reg(`OFS_MUX, 8'hc3);
        chk("inert channel", 10'h000, {5'h00, channel_select});
        wr_reg(`OFS_CSA, 8'hc0);
        rd_chk(`OFS_CSA, 8'hc0, "start busy");
        wait_done(len);
        chk("first length", 10'h001, {9'h000, len >= 44 && len <= 58});
        rd_chk(`OFS_CSA, 8'h90, "start cleared flag set");
        rd_chk(`OFS_RES_LO, 8'h61, "right low");
        rd_chk(`OFS_RES_HI, 8'h00, "right high");
        // Channel change in mid-conversion
        wr_reg(`OFS_CSA, 8'hd0);
        repeat (4) @(posedge clk);
        wr_reg(`OFS_MUX, 8'hc5);
        wait_done(len);
        chk("normal length", 10'h001, {9'h000, len >= 18 && len <= 32});
        chk("new channel", 10'h005, {5'h00, channel_select});
        chk("active reference", 10'h003, {8'h00, reference_select});
        rd_chk(`OFS_RES_LO, 8'h62, "old channel");
        rd_chk(`OFS_RES_HI, 8'h00, "old high");
        // Lock by low read, completion discarded
        rd_chk(`OFS_RES_LO, 8'h62, "lock read");
        wr_reg(`OFS_CSA, 8'hd0);
        wait_done(len);
        rd_chk(`OFS_CSA, 8'h90, "flag despite lock");
        rd_chk(`OFS_RES_HI, 8'h00, "held high");
        rd_chk(`OFS_RES_LO, 8'h62, "discarded");
        rd_chk(`OFS_RES_HI, 8'h00, "unlock");
        // Left adjusted, high byte only
        wr_reg(`OFS_MUX, 8'he5);
        wr_reg(`OFS_CSA, 8'hd0);
        wait_done(len);
        rd_chk(`OFS_RES_HI, 8'h29, "left high");
        // Auto trigger with a second edge during conversion
        wr_reg(`OFS_CSB, 8'h01);
        wr_reg(`OFS_CSA, 8'hb0);
        @(posedge clk);
        trigger_sources <= 8'h02;
        repeat (8) @(posedge clk);
        rd_chk(`OFS_CSA, 8'he0, "auto busy");
        @(posedge clk);
        trigger_sources <= 8'h00;
        @(posedge clk);
        trigger_sources <= 8'h02;
        wait_done(len);
        chk("auto length", 10'h001, {9'h000, len >= 10 && len <= 36});
        rd_chk(`OFS_RES_LO, 8'h40, "auto low");
        rd_chk(`OFS_RES_HI, 8'h29, "auto high");
        wait_done(len);
        chk("held trigger", 10'h000, {9'h000, conversion_done});
        // source flag cleared before its next event
        @(posedge clk);
        trigger_sources <= 8'h00;
        // Free run on own flag, then stop
        wr_reg(`OFS_CSB, 8'h00);
        wr_reg(`OFS_CSA, 8'hf0);
        wait_done(len);
        wait_done(len);
        chk("free run", 10'h001, {9'h000, conversion_done});
        rd_chk(`OFS_CSA, 8'hf0, "free run busy");
        wr_reg(`OFS_CSA, 8'h80);
        wait_done(len);
        chk("last finishes", 10'h001, {9'h000, conversion_done});
        rd_chk(`OFS_RES_LO, 8'h00, "free low");
        rd_chk(`OFS_RES_HI, 8'h2a, "free high");
        wr_reg(`OFS_CSA, 8'h00);
        chk("disabled", 10'h000, {9'h000, analog_enable});
        end_of_test();
    end
endmodule : sar_adc_control_and_trigger_tb
